// ---- charger_cfg_pkg.sv ----
// constants for the charger gate-drive configuration register bank
// assumes a 100 MHz core clock and millivolt-scaled sense codes
package charger_cfg_pkg;

    localparam int unsigned CLK_MHZ = 100;

    // register offsets
    localparam logic [7:0] DEAD_TIME_CONTROL_ADDR       = 8'h3C;
    localparam logic [7:0] PART_IDENTIFICATION_ADDR     = 8'h3D;
    localparam logic [7:0] FEEDBACK_REF_LOW_ADDR        = 8'h3E;
    localparam logic [7:0] FEEDBACK_REF_HIGH_ADDR       = 8'h3F;
    localparam logic [7:0] SOFT_RESET_CONTROL_ADDR      = 8'h40;
    localparam logic [7:0] WINDOW_STATUS_ADDR           = 8'h41;
    localparam logic [7:0] REVERSE_DISCHARGE_LIMIT_ADDR = 8'h62;

    // field positions
    localparam int unsigned BOOST_DEAD_LSB    = 2;
    localparam int unsigned BUCK_DEAD_LSB     = 0;
    localparam int unsigned DISCHARGE_CAP_LSB = 6;
    localparam int unsigned QUICK_RESP_BIT    = 1;
    localparam int unsigned PART_FIELD_LSB    = 3;
    localparam int unsigned SOFT_RESET_BIT    = 0;

    // reset values
    localparam logic [3:0]  DEAD_TIME_RESET     = 4'h0;
    localparam logic [1:0]  DISCHARGE_CAP_RESET = 2'h0;
    localparam logic        QUICK_RESP_RESET    = 1'b1;
    localparam logic [15:0] FEEDBACK_REF_RESET  = 16'h0600;

    // dead times, least times rounded up to whole cycles
    localparam int unsigned DEAD_NS_00 = 45;
    localparam int unsigned DEAD_NS_01 = 75;
    localparam int unsigned DEAD_NS_10 = 105;
    localparam int unsigned DEAD_NS_11 = 135;
    localparam logic [3:0] DEAD_CYC_00 = 4'((DEAD_NS_00 * CLK_MHZ + 999) / 1000);
    localparam logic [3:0] DEAD_CYC_01 = 4'((DEAD_NS_01 * CLK_MHZ + 999) / 1000);
    localparam logic [3:0] DEAD_CYC_10 = 4'((DEAD_NS_10 * CLK_MHZ + 999) / 1000);
    localparam logic [3:0] DEAD_CYC_11 = 4'((DEAD_NS_11 * CLK_MHZ + 999) / 1000);

    // input window thresholds in millivolts
    localparam logic [15:0] HIGH_SENSE_REF_MV = 16'h04B0;
    localparam logic [15:0] LOW_SENSE_REF_MV  = 16'h044C;
    localparam logic [15:0] SUPPLY_MIN_MV     = 16'h1068;
    localparam logic [15:0] SUPPLY_MAX_MV     = 16'hEA60;

endpackage

// ---- serial_reg_port.sv ----
// two-wire serial register port: pointer write, auto-increment reads/writes
// assumes SCL/SDA already synchronous to the core clock; SDA is open drain
module serial_reg_port
    import charger_cfg_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2A
)
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output      logic       sda_oe,
    output      logic       wr_en,
    output      logic [7:0] wr_addr,
    output      logic [7:0] wr_data,
    output      logic [7:0] rd_addr,
    input  wire logic [7:0] rd_data
);
    typedef enum logic [2:0] {IDLE, ADDR, ACK_ADDR, WRITE, ACK_WR, READ, ACK_RD} port_state_t;

    port_state_t state_reg, state_next;
    logic       scl_prev_reg, sda_prev_reg;
    logic [7:0] sh_reg, sh_next, ptr_reg, ptr_next, tx_reg, tx_next;
    logic [3:0] cnt_reg, cnt_next;
    logic       oe_reg, oe_next, ptr_phase_reg, ptr_phase_next, rw_reg, rw_next;
    logic       ok_reg, ok_next, wr_reg, wr_next;
    logic       scl_rise, scl_fall, start_cond, stop_cond;

    assign scl_rise   = scl_in & ~scl_prev_reg;
    assign scl_fall   = ~scl_in & scl_prev_reg;
    assign start_cond = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
    assign stop_cond  = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;

    always_comb
    begin
        state_next     = state_reg;
        sh_next        = sh_reg;
        ptr_next       = ptr_reg;
        tx_next        = tx_reg;
        cnt_next       = cnt_reg;
        oe_next        = oe_reg;
        ptr_phase_next = ptr_phase_reg;
        rw_next        = rw_reg;
        ok_next        = ok_reg;
        wr_next        = 1'b0;
        if (start_cond)
        begin
            state_next = ADDR;
            cnt_next   = 4'h0;
            oe_next    = 1'b0;
        end
        else if (stop_cond)
        begin
            state_next = IDLE;
            oe_next    = 1'b0;
        end
        else if (scl_rise)
        begin
            if (state_reg == ADDR || state_reg == WRITE)
            begin
                sh_next  = {sh_reg[6:0], sda_in};
                cnt_next = cnt_reg + 4'h1;
            end
            else if (state_reg == ACK_RD)
                ok_next = ~sda_in;
        end
        else if (scl_fall)
        begin
            unique case (state_reg)
                IDLE: ;
                ADDR:
                    if (cnt_reg == 4'h8)
                    begin
                        // foreign address: stay off the bus until next start
                        state_next = (sh_reg[7:1] == DEV_ADDR) ? ACK_ADDR : IDLE;
                        oe_next    = (sh_reg[7:1] == DEV_ADDR);
                        rw_next    = sh_reg[0];
                    end
                ACK_ADDR:
                    if (rw_reg)
                    begin
                        state_next = READ;
                        tx_next    = rd_data;
                        oe_next    = ~rd_data[7];
                        cnt_next   = 4'h1;
                    end
                    else
                    begin
                        state_next     = WRITE;
                        oe_next        = 1'b0;
                        cnt_next       = 4'h0;
                        ptr_phase_next = 1'b1;
                    end
                WRITE:
                    if (cnt_reg == 4'h8)
                    begin
                        state_next = ACK_WR;
                        oe_next    = 1'b1;
                        if (ptr_phase_reg)
                            ptr_next = sh_reg;
                        else
                            wr_next = 1'b1;
                    end
                ACK_WR:
                begin
                    state_next = WRITE;
                    oe_next    = 1'b0;
                    cnt_next   = 4'h0;
                    if (!ptr_phase_reg)
                        ptr_next = ptr_reg + 8'h01;
                    ptr_phase_next = 1'b0;
                end
                READ:
                    if (cnt_reg == 4'h8)
                    begin
                        state_next = ACK_RD;
                        oe_next    = 1'b0;
                        ptr_next   = ptr_reg + 8'h01;
                    end
                    else
                    begin
                        oe_next  = ~tx_reg[3'(4'h7 - cnt_reg)];
                        cnt_next = cnt_reg + 4'h1;
                    end
                ACK_RD:
                    if (ok_reg)
                    begin
                        state_next = READ;
                        tx_next    = rd_data;
                        oe_next    = ~rd_data[7];
                        cnt_next   = 4'h1;
                    end
                    else
                        state_next = IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg     <= IDLE;
            scl_prev_reg  <= 1'b1;
            sda_prev_reg  <= 1'b1;
            sh_reg        <= 8'h00;
            ptr_reg       <= 8'h00;
            tx_reg        <= 8'h00;
            cnt_reg       <= 4'h0;
            oe_reg        <= 1'b0;
            ptr_phase_reg <= 1'b0;
            rw_reg        <= 1'b0;
            ok_reg        <= 1'b0;
            wr_reg        <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            scl_prev_reg  <= scl_in;
            sda_prev_reg  <= sda_in;
            sh_reg        <= sh_next;
            ptr_reg       <= ptr_next;
            tx_reg        <= tx_next;
            cnt_reg       <= cnt_next;
            oe_reg        <= oe_next;
            ptr_phase_reg <= ptr_phase_next;
            rw_reg        <= rw_next;
            ok_reg        <= ok_next;
            wr_reg        <= wr_next;
        end
    end

    assign sda_oe  = oe_reg;
    assign wr_en   = wr_reg;
    assign wr_addr = ptr_reg;
    assign wr_data = sh_reg;
    assign rd_addr = ptr_reg;

endmodule // serial_reg_port

// ---- charger_gate_drive_config_regs.sv ----
// charger gate-drive configuration registers, dead-time insertion, input window
// assumes sense inputs are millivolt codes synchronous to SYS_CLK
module charger_gate_drive_config_regs
    import charger_cfg_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR      = 7'h2A,
    parameter logic [3:0] PART_NUMBER   = 4'h5,  // arbitrary value
    parameter logic [2:0] REVISION_CODE = 3'h1   // arbitrary value
)
(
    input  wire logic        SYS_CLK,
    input  wire logic        ARST_N,
    input  wire logic        SCL,
    input  wire logic        SDA_IN,
    output      logic        SDA_OUT,
    output      logic        SDA_OE,
    input  wire logic        BOOST_PWM,
    input  wire logic        BUCK_PWM,
    input  wire logic        REVERSE_MODE,
    input  wire logic [15:0] INPUT_LOW_WINDOW_SENSE,
    input  wire logic [15:0] INPUT_HIGH_WINDOW_SENSE,
    input  wire logic [15:0] INPUT_SUPPLY_VOLTAGE,
    output      logic        BOOST_HS_ON,
    output      logic        BOOST_LS_ON,
    output      logic        BUCK_HS_ON,
    output      logic        BUCK_LS_ON,
    output      logic        CONVERTER_STOP,
    output      logic [1:0]  REVERSE_DISCHARGE_CAP,
    output      logic        REVERSE_QUICK_RESPONSE_ENABLE,
    output      logic [15:0] FEEDBACK_REFERENCE_SETTING
);
    logic        wr_en;
    logic [7:0]  wr_addr, wr_data, rd_addr;
    logic [7:0]  rd_data;

    logic [3:0]  dead_reg, dead_next;
    logic [1:0]  cap_reg, cap_next;
    logic        quick_reg, quick_next;
    logic        quick_out_reg, quick_out_next;
    logic [15:0] fbref_reg, fbref_next;
    logic        uv_reg, uv_next, ov_reg, ov_next, sup_reg, sup_next;
    logic        stop_reg, stop_next;
    logic        sda_reg;
    logic        soft_reset;

    serial_reg_port #(
        .DEV_ADDR (DEV_ADDR)
    ) u_port (
        .clk     (SYS_CLK),
        .arst_n  (ARST_N),
        .scl_in  (SCL),
        .sda_in  (SDA_IN),
        .sda_oe  (SDA_OE),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    assign soft_reset = wr_en && wr_addr == SOFT_RESET_CONTROL_ADDR && wr_data[SOFT_RESET_BIT];

    // register writes; the reset command goes first
    always_comb
    begin
        dead_next  = dead_reg;
        cap_next   = cap_reg;
        quick_next = quick_reg;
        fbref_next = fbref_reg;
        if (soft_reset)
        begin
            dead_next  = DEAD_TIME_RESET;
            cap_next   = DISCHARGE_CAP_RESET;
            quick_next = QUICK_RESP_RESET;
            fbref_next = FEEDBACK_REF_RESET;
        end
        else if (wr_en)
        begin
            unique case (wr_addr)
                DEAD_TIME_CONTROL_ADDR:
                    dead_next = wr_data[3:0];
                REVERSE_DISCHARGE_LIMIT_ADDR:
                begin
                    cap_next   = wr_data[DISCHARGE_CAP_LSB +: 2];
                    quick_next = wr_data[QUICK_RESP_BIT];
                end
                FEEDBACK_REF_LOW_ADDR:
                    fbref_next[7:0] = wr_data;
                FEEDBACK_REF_HIGH_ADDR:
                    fbref_next[15:8] = wr_data;
                default: ;
            endcase
        end
    end

    // read mux; unused and reserved bits stay zero
    always_comb
    begin
        rd_data = 8'h00;
        unique case (rd_addr)
            DEAD_TIME_CONTROL_ADDR:
                rd_data = {4'h0, dead_reg};
            PART_IDENTIFICATION_ADDR:
                rd_data = {1'b0, PART_NUMBER, REVISION_CODE};
            REVERSE_DISCHARGE_LIMIT_ADDR:
                rd_data = {cap_reg, 4'h0, quick_reg, 1'b0};
            FEEDBACK_REF_LOW_ADDR:
                rd_data = fbref_reg[7:0];
            FEEDBACK_REF_HIGH_ADDR:
                rd_data = fbref_reg[15:8];
            WINDOW_STATUS_ADDR:
                rd_data = {4'h0, sup_reg, ov_reg, uv_reg, stop_reg};
            default:
                rd_data = 8'h00;
        endcase
    end

    // input window, registered twice (flags, then stop) so every gate sees the same decision
    always_comb
    begin
        ov_next        = INPUT_HIGH_WINDOW_SENSE > HIGH_SENSE_REF_MV;
        uv_next        = INPUT_LOW_WINDOW_SENSE < LOW_SENSE_REF_MV;
        sup_next       = INPUT_SUPPLY_VOLTAGE < SUPPLY_MIN_MV
                      || INPUT_SUPPLY_VOLTAGE > SUPPLY_MAX_MV;
        stop_next      = ov_reg | uv_reg | sup_reg;
        quick_out_next = quick_reg & REVERSE_MODE;
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            dead_reg      <= DEAD_TIME_RESET;
            cap_reg       <= DISCHARGE_CAP_RESET;
            quick_reg     <= QUICK_RESP_RESET;
            fbref_reg     <= FEEDBACK_REF_RESET;
            uv_reg        <= 1'b0;
            ov_reg        <= 1'b0;
            sup_reg       <= 1'b1; // holds stop until first sample
            stop_reg      <= 1'b1;
            quick_out_reg <= 1'b0;
            sda_reg       <= 1'b0;
        end
        else
        begin
            dead_reg      <= dead_next;
            cap_reg       <= cap_next;
            quick_reg     <= quick_next;
            fbref_reg     <= fbref_next;
            uv_reg        <= uv_next;
            ov_reg        <= ov_next;
            sup_reg       <= sup_next;
            stop_reg      <= stop_next;
            quick_out_reg <= quick_out_next;
            sda_reg       <= 1'b0;
        end
    end

    // dead-time insertion, leg 0 buck, leg 1 boost
    logic [1:0] pwm_in;
    logic [1:0] gate_reg [2];
    assign pwm_in = {BOOST_PWM, BUCK_PWM};

    for (genvar leg = 0; leg < 2; leg++)
    begin : g_leg
        logic [1:0] sel;
        logic [3:0] dead_cyc;
        logic [3:0] cnt_reg, cnt_next;
        logic [1:0] gate_next, want;

        assign sel = (leg == 1) ? dead_reg[BOOST_DEAD_LSB +: 2]
                                : dead_reg[BUCK_DEAD_LSB +: 2];

        always_comb
        begin
            unique case (sel)
                2'b00: dead_cyc = DEAD_CYC_00;
                2'b01: dead_cyc = DEAD_CYC_01;
                2'b10: dead_cyc = DEAD_CYC_10;
                2'b11: dead_cyc = DEAD_CYC_11;
            endcase
            // {high side, low side}; never both, both off the cycle after stop is set
            want      = stop_reg ? 2'b00 : (pwm_in[leg] ? 2'b10 : 2'b01);
            gate_next = gate_reg[leg];
            cnt_next  = cnt_reg;
            if (want != gate_reg[leg])
            begin
                if (gate_reg[leg] != 2'b00)
                begin
                    gate_next = 2'b00;
                    cnt_next  = dead_cyc - 4'h1;
                end
                else if (cnt_reg != 4'h0)
                    cnt_next = cnt_reg - 4'h1;
                else
                    gate_next = want;
            end
        end

        always_ff @(posedge SYS_CLK or negedge ARST_N)
        begin
            if (!ARST_N)
            begin
                gate_reg[leg] <= 2'b00;
                cnt_reg       <= 4'h0;
            end
            else
            begin
                gate_reg[leg] <= gate_next;
                cnt_reg       <= cnt_next;
            end
        end
    end

    assign BUCK_HS_ON                    = gate_reg[0][1];
    assign BUCK_LS_ON                    = gate_reg[0][0];
    assign BOOST_HS_ON                   = gate_reg[1][1];
    assign BOOST_LS_ON                   = gate_reg[1][0];
    assign CONVERTER_STOP                = stop_reg;
    assign REVERSE_DISCHARGE_CAP         = cap_reg;
    assign REVERSE_QUICK_RESPONSE_ENABLE = quick_out_reg;
    assign FEEDBACK_REFERENCE_SETTING    = fbref_reg;
    assign SDA_OUT                       = sda_reg;

endmodule // charger_gate_drive_config_regs

// ---- charger_cfg_checker_assertions.sv ----
// assertions for the charger configuration register bank
// sees top ports only; bound at the foot
module charger_cfg_checker
    import charger_cfg_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        ARST_N,
    input  wire logic        BOOST_PWM,
    input  wire logic        REVERSE_MODE,
    input  wire logic [15:0] INPUT_LOW_WINDOW_SENSE,
    input  wire logic [15:0] INPUT_HIGH_WINDOW_SENSE,
    input  wire logic [15:0] INPUT_SUPPLY_VOLTAGE,
    input  wire logic        BOOST_HS_ON,
    input  wire logic        BOOST_LS_ON,
    input  wire logic        BUCK_HS_ON,
    input  wire logic        BUCK_LS_ON,
    input  wire logic        CONVERTER_STOP,
    input  wire logic [1:0]  REVERSE_DISCHARGE_CAP,
    input  wire logic        REVERSE_QUICK_RESPONSE_ENABLE,
    input  wire logic [15:0] FEEDBACK_REFERENCE_SETTING
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);

    logic in_window;
    assign in_window = (INPUT_HIGH_WINDOW_SENSE <= HIGH_SENSE_REF_MV)
                    && (INPUT_LOW_WINDOW_SENSE >= LOW_SENSE_REF_MV)
                    && (INPUT_SUPPLY_VOLTAGE >= SUPPLY_MIN_MV)
                    && (INPUT_SUPPLY_VOLTAGE <= SUPPLY_MAX_MV);

    boost_overlap_a: assert property (!(BOOST_HS_ON && BOOST_LS_ON))
        else $error("boost gates on together");
    buck_dead_min_a: assert property ($fell(BUCK_HS_ON) |-> !BUCK_LS_ON [*5])
        else $error("buck dead time short");
    boost_turn_off_a: assert property (BOOST_HS_ON && !BOOST_PWM |=> !BOOST_HS_ON)
        else $error("boost high side late off");
    over_trip_a: assert property (INPUT_HIGH_WINDOW_SENSE > HIGH_SENSE_REF_MV |-> ##2 CONVERTER_STOP)
        else $error("over-voltage no stop");
    under_trip_a: assert property (INPUT_LOW_WINDOW_SENSE < LOW_SENSE_REF_MV |-> ##2 CONVERTER_STOP)
        else $error("under-voltage no stop");
    supply_trip_a: assert property ((INPUT_SUPPLY_VOLTAGE < SUPPLY_MIN_MV
        || INPUT_SUPPLY_VOLTAGE > SUPPLY_MAX_MV) |-> ##2 CONVERTER_STOP)
        else $error("supply window no stop");
    in_window_a: assert property (in_window |-> ##2 !CONVERTER_STOP)
        else $error("stop inside window");
    stop_gates_off_a: assert property (CONVERTER_STOP |=>
        !(BOOST_HS_ON || BOOST_LS_ON || BUCK_HS_ON || BUCK_LS_ON))
        else $error("gate on after stop");
    quick_mode_a: assert property (!REVERSE_MODE |=> !REVERSE_QUICK_RESPONSE_ENABLE)
        else $error("quick outside reverse");
    reset_values_a: assert property ($rose(ARST_N) |->
        FEEDBACK_REFERENCE_SETTING == FEEDBACK_REF_RESET && REVERSE_DISCHARGE_CAP == 2'h0)
        else $error("bad reset value");
endmodule // charger_cfg_checker

bind charger_gate_drive_config_regs charger_cfg_checker u_chk (
    .SYS_CLK, .ARST_N, .BOOST_PWM, .REVERSE_MODE, .INPUT_LOW_WINDOW_SENSE,
    .INPUT_HIGH_WINDOW_SENSE, .INPUT_SUPPLY_VOLTAGE, .BOOST_HS_ON, .BOOST_LS_ON,
    .BUCK_HS_ON, .BUCK_LS_ON, .CONVERTER_STOP, .REVERSE_DISCHARGE_CAP,
    .REVERSE_QUICK_RESPONSE_ENABLE, .FEEDBACK_REFERENCE_SETTING);

// ---- serial_host_model.sv ----
// two-wire host model that programs the charger registers
// assumes a pull-up on the data wire; tasks are entered just after a clock edge
module serial_host_model
#(
    parameter logic [6:0] DEV_ADDR = 7'h2A
)
(
    input  wire logic clk,
    input  wire logic sda_line,
    output      logic scl,
    output      logic sda_low
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // four clocks a phase keep edges apart for the port
    task automatic tick();
        repeat (4) @(posedge clk);
    endtask

    task automatic bit_io(input logic b, output logic r);
        sda_low <= !b;
        tick();
        scl <= 1'b1;
        tick();
        r = sda_line;
        scl <= 1'b0;
        tick();
    endtask

    task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack_n);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(1'b1, ack_n);
    endtask

    task automatic start_cond();
        sda_low <= 1'b0;
        tick();
        scl <= 1'b1;
        tick();
        sda_low <= 1'b1;
        tick();
        scl <= 1'b0;
        tick();
    endtask

    task automatic stop_cond();
        sda_low <= 1'b1;
        tick();
        scl <= 1'b1;
        tick();
        sda_low <= 1'b0;
        tick();
    endtask

    // settings go in before anything relies on them
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data, output logic ok);
        logic [7:0] d;
        logic       a0, a1, a2;
        start_cond();
        byte_io({DEV_ADDR, 1'b0}, d, a0);
        byte_io(addr, d, a1);
        byte_io(data, d, a2);
        stop_cond();
        ok = !(a0 || a1 || a2);
    endtask

    // one byte, closed by a not-acknowledge
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        logic [7:0] d;
        logic       a0, a1, a2;
        start_cond();
        byte_io({DEV_ADDR, 1'b0}, d, a0);
        byte_io(addr, d, a1);
        start_cond();
        byte_io({DEV_ADDR, 1'b1}, d, a2);
        byte_io(8'hFF, data, d[0]);
        stop_cond();
        ok = !(a0 || a1 || a2);
    endtask
endmodule // serial_host_model

// ---- charger_gate_drive_config_regs_tb.sv ----
// self-checking bench for the charger configuration register bank
// assumes the host model owns the bus; data wire pulled up
module charger_gate_drive_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import charger_cfg_pkg::*;
    localparam logic [3:0] PART = 4'h5;  // arbitrary value
    localparam logic [2:0] REV  = 3'h1;  // arbitrary value
    logic        sys_clk, arst_n, scl, host_low, sda_out, sda_oe, reverse_mode;
    logic        boost_pwm, buck_pwm, boost_hs, boost_ls, buck_hs, buck_ls, conv_stop, quick;
    logic [15:0] low_sense, high_sense, supply, fb_ref;
    logic [1:0]  cap;
    int          bad_count, cmp_count, nb, nk;
    wire         sda_line = (host_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
    // low, high, supply, stop; limits from both sides
    logic [15:0] win_tab [7][4] = '{'{16'h044C, 16'h04B0, 16'h1068, 16'h0000},
        '{16'h044B, 16'h04B0, 16'h1068, 16'h0001}, '{16'h044C, 16'h04B1, 16'h2EE0, 16'h0001},
        '{16'h04B0, 16'h047E, 16'h1067, 16'h0001}, '{16'h04B0, 16'h047E, 16'hEA60, 16'h0000},
        '{16'h04B0, 16'h047E, 16'hEA61, 16'h0001}, '{16'h04B0, 16'h047E, 16'h2EE0, 16'h0000}};

    charger_gate_drive_config_regs #(.PART_NUMBER(PART), .REVISION_CODE(REV)) DUT (
        .SYS_CLK(sys_clk), .ARST_N(arst_n), .SCL(scl), .SDA_IN(sda_line), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .BOOST_PWM(boost_pwm), .BUCK_PWM(buck_pwm), .REVERSE_MODE(reverse_mode),
        .INPUT_LOW_WINDOW_SENSE(low_sense), .INPUT_HIGH_WINDOW_SENSE(high_sense),
        .INPUT_SUPPLY_VOLTAGE(supply), .BOOST_HS_ON(boost_hs), .BOOST_LS_ON(boost_ls),
        .BUCK_HS_ON(buck_hs), .BUCK_LS_ON(buck_ls), .CONVERTER_STOP(conv_stop),
        .REVERSE_DISCHARGE_CAP(cap), .REVERSE_QUICK_RESPONSE_ENABLE(quick),
        .FEEDBACK_REFERENCE_SETTING(fb_ref));
    serial_host_model host (.clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_low(host_low));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        logic ok;
        host.write_reg(addr, data, ok);
        check("write ack", {15'h0000, ok}, 16'h0001);
    endtask
    task automatic rd(input string what, input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        host.read_reg(addr, d, ok);
        check({what, " ack"}, {15'h0000, ok}, 16'h0001);
        check(what, {8'h00, d}, {8'h00, exp});
    endtask
    function automatic logic [15:0] dead_cyc(input int code);
        int ns [4] = '{45, 75, 105, 135};
        return 16'((ns[code] * 100 + 999) / 1000);
    endfunction
    // off cycles per leg after a rising request
    task automatic measure();
        nb = 0;
        nk = 0;
        boost_pwm <= 1'b1;
        buck_pwm  <= 1'b1;
        repeat (40)
        begin
            @(posedge sys_clk);
            #1;
            nb += int'(!boost_hs && !boost_ls);
            nk += int'(!buck_hs && !buck_ls);
        end
        @(posedge sys_clk);
        boost_pwm <= 1'b0;
        buck_pwm  <= 1'b0;
        repeat (40) @(posedge sys_clk);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (80000) @(posedge sys_clk);
        bad_count++;
        print_verdict();
    end

    initial
    begin
        arst_n = 1'b0;
        boost_pwm = 1'b0;
        buck_pwm = 1'b0;
        reverse_mode = 1'b0;
        low_sense = 16'h04B0;
        high_sense = 16'h047E;
        supply = 16'h2EE0;
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (60) @(posedge sys_clk);
        rd("dead reset", DEAD_TIME_CONTROL_ADDR, 8'h00);
        rd("reverse reset", REVERSE_DISCHARGE_LIMIT_ADDR, 8'h02);
        rd("part id", PART_IDENTIFICATION_ADDR, {1'b0, PART, REV});
        check("feedback reset", fb_ref, 16'h0600);
        $display("reset value test done");
        wr(DEAD_TIME_CONTROL_ADDR, 8'hFF);
        rd("dead reserved", DEAD_TIME_CONTROL_ADDR, 8'h0F);
        wr(PART_IDENTIFICATION_ADDR, 8'hFF);
        rd("part id kept", PART_IDENTIFICATION_ADDR, {1'b0, PART, REV});
        wr(REVERSE_DISCHARGE_LIMIT_ADDR, 8'hFF);
        rd("reverse reserved", REVERSE_DISCHARGE_LIMIT_ADDR, 8'hC2);
        reverse_mode <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check("quick on", {15'h0000, quick}, 16'h0001);
        wr(REVERSE_DISCHARGE_LIMIT_ADDR, 8'h00);
        check("quick off", {15'h0000, quick}, 16'h0000);
        reverse_mode <= 1'b0;
        for (int c = 0; c < 4; c++)
        begin
            wr(REVERSE_DISCHARGE_LIMIT_ADDR, {2'(c), 6'h02});
            check("cap out", {14'h0000, cap}, 16'(c));
            rd("cap read", REVERSE_DISCHARGE_LIMIT_ADDR, {2'(c), 6'h02});
        end
        $display("field test done");
        for (int c = 0; c < 4; c++)
        begin
            wr(DEAD_TIME_CONTROL_ADDR, {4'h0, 2'(c), 2'(3 - c)});
            measure();
            check("boost dead", 16'(nb), dead_cyc(c));
            check("buck dead", 16'(nk), dead_cyc(3 - c));
        end
        $display("dead time test done");
        wr(FEEDBACK_REF_LOW_ADDR, 8'h00);
        wr(FEEDBACK_REF_HIGH_ADDR, 8'h05);
        check("feedback set", fb_ref, 16'h0500);
        rd("feedback high", FEEDBACK_REF_HIGH_ADDR, 8'h05);
        wr(SOFT_RESET_CONTROL_ADDR, 8'h01);
        rd("dead soft", DEAD_TIME_CONTROL_ADDR, 8'h00);
        rd("reverse soft", REVERSE_DISCHARGE_LIMIT_ADDR, 8'h02);
        check("feedback soft", fb_ref, 16'h0600);
        check("cap soft", {14'h0000, cap}, 16'h0000);
        $display("register reset test done");
        boost_pwm <= 1'b1;
        buck_pwm  <= 1'b1;
        for (int r = 0; r < 7; r++)
        begin
            @(posedge sys_clk);
            low_sense  <= win_tab[r][0];
            high_sense <= win_tab[r][1];
            supply     <= win_tab[r][2];
            repeat (30) @(posedge sys_clk);
            #1;
            check("stop", {15'h0000, conv_stop}, win_tab[r][3]);
            check("gates", {15'h0000, boost_hs && buck_hs}, ~win_tab[r][3] & 16'h0001);
        end
        $display("window test done");
        @(posedge sys_clk);
        wr(REVERSE_DISCHARGE_LIMIT_ADDR, 8'hC0);
        arst_n <= 1'b0;
        @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (60) @(posedge sys_clk);
        check("cap after reset", {14'h0000, cap}, 16'h0000);
        rd("reverse after reset", REVERSE_DISCHARGE_LIMIT_ADDR, 8'h02);
        $display("second reset test done");
        print_verdict();
    end
endmodule // charger_gate_drive_config_regs_tb
